// ==== dv/undp_data_port_sva.sv ====
// Port-level assertions for the ninth-bit data port
`timescale 1ns/1ps
module undp_data_port_sva
    import undp_pkg::*;
(
    // Clock and reset
    input wire logic             aclk,
    input wire logic             aresetn,
    input wire logic             ce,
    // Bus, shifter and pins
    input wire undp_axi_req_type axi_req,
    input wire undp_axi_rsp_type axi_rsp,
    input wire logic             loopback_select,
    input wire logic             rx_source_select,
    input wire undp_rx_char_type rx_char,
    input wire undp_tx_load_type tx_load,
    input wire logic             tx_load_ready,
    input wire logic             tx_shift_bit,
    input wire logic             txd_out,
    input wire logic             txd_oe,
    input wire logic             rx_buffer_full_flag,
    input wire logic             err_irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_both_s;
        axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
    endsequence
    sequence rd_taken_s;
        axi_req.arvalid && axi_rsp.arready;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    reset_clear_a: assert property (disable iff (1'b0) !aresetn && ce |=> !err_irq && !tx_load.valid &&
        !rx_buffer_full_flag && !axi_rsp.bvalid && !axi_rsp.rvalid &&
        txd_oe == !(loopback_select && rx_source_select) && txd_out == tx_shift_bit)
        else $error("state not cleared by reset");
    bresp_time_a: assert property (wr_both_s |=> !axi_rsp.bvalid ##1 axi_rsp.bvalid)
        else $error("write response not two cycles after handshake");
    rdata_time_a: assert property (rd_taken_s |=> axi_rsp.rvalid && axi_rsp.rdata[31:8] == 24'h00_0000)
        else $error("read data late or upper bits set");
    tx_hold_a: assert property (tx_load.valid && !tx_load_ready |=> tx_load.valid)
        else $error("waiting transmit word dropped");
    tx_frame_a: assert property (tx_load.valid |-> !tx_load.word[0] && tx_load.word[10] &&
        (tx_load.len == FRAME_LEN_9 || tx_load.len == FRAME_LEN_8 && tx_load.word[9]))
        else $error("transmit word badly framed");
    rx_load_a: assert property (rx_char.valid && !rx_buffer_full_flag |=> rx_buffer_full_flag)
        else $error("receive buffer full not set");
    oe_plain_a: assert property (!(loopback_select && rx_source_select) |-> txd_oe)
        else $error("pin not driven outside single-wire mode");
    irq_cause_a: assert property ($rose(err_irq) |-> $past(rx_char.valid) || $rose(axi_rsp.bvalid))
        else $error("interrupt rose without cause");
    flip_cause_a: assert property ($changed(txd_out) |-> $changed(tx_shift_bit) || $rose(axi_rsp.bvalid))
        else $error("transmit output moved on its own");
endmodule : undp_data_port_sva

bind undp_data_port undp_data_port_sva undp_data_port_sva_i (.aclk, .aresetn, .ce, .axi_req, .axi_rsp,
    .loopback_select, .rx_source_select, .rx_char, .tx_load, .tx_load_ready, .tx_shift_bit, .txd_out, .txd_oe,
    .rx_buffer_full_flag, .err_irq);

// ==== dv/undp_data_port_test.sv ====
// Register-level test of the ninth-bit data port
`timescale 1ns/1ps
module undp_data_port_test;
    import undp_pkg::*;
    logic             aclk = 1'b0;
    logic             aresetn = 1'b0;
    logic             nine_bit_mode = 1'b0;
    logic             loopback_select = 1'b0;
    logic             rx_source_select = 1'b0;
    undp_axi_req_type axi_req = '0;
    undp_axi_rsp_type axi_rsp;
    undp_rx_char_type rx_char;
    undp_tx_load_type tx_load;
    logic             tx_load_ready, tx_shift_bit, txd_out, txd_oe, rx_buffer_full_flag, err_irq;
    logic [31:0]      rd;
    logic [1:0]       rs;
    logic [7:0]       tx_bytes [4] = '{8'hA5, 8'h3C, 8'h5A, 8'hC3};
    int               n_fail = 0;
    int               checked = 0;
    always #4 aclk = ~aclk;
    undp_data_port undp_data_port_i (.aclk, .aresetn, .ce(1'b1), .axi_req, .axi_rsp, .nine_bit_mode, .loopback_select,
        .rx_source_select, .rx_char, .tx_load, .tx_load_ready, .tx_shift_bit, .txd_out, .txd_oe, .rx_buffer_full_flag,
        .err_irq);
    undp_shifter_model undp_shifter_model_i (.aclk, .aresetn, .tx_load, .tx_load_ready, .tx_shift_bit, .rx_char);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tmo;
        n_fail++;
        $display("mismatch handshake expected answer seen none");
        end_of_test();
    endtask : tmo
    task automatic fin(input string s);
        $display("test %s finished", s);
    endtask : fin
    function automatic logic [11:0] ad(input logic [7:0] i, input logic [9:0] b = BLOCK_BASE);
        return {b + {2'b00, i}, 2'b00};
    endfunction : ad
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        int   n;
        logic aw, w, b;
        n = 0;
        axi_req.awvalid <= 1'b1;
        axi_req.awaddr <= a;
        axi_req.wvalid <= 1'b1;
        axi_req.wdata <= {24'h00_0000, d};
        axi_req.wstrb <= 4'hF;
        axi_req.bready <= 1'b1;
        do begin
            @(negedge aclk);
            aw = axi_req.awvalid & axi_rsp.awready;
            w = axi_req.wvalid & axi_rsp.wready;
            b = axi_rsp.bvalid;
            rs = axi_rsp.bresp;
            @(posedge aclk);
            n++;
            if (aw) axi_req.awvalid <= 1'b0;
            if (w) axi_req.wvalid <= 1'b0;
        end while (!b && n < 50);
        axi_req.bready <= 1'b0;
        @(posedge aclk);
        if (!b) tmo();
    endtask : wr
    task automatic rdr(input logic [11:0] a);
        int   n;
        logic ar, r;
        n = 0;
        axi_req.arvalid <= 1'b1;
        axi_req.araddr <= a;
        axi_req.rready <= 1'b1;
        do begin
            @(negedge aclk);
            ar = axi_req.arvalid & axi_rsp.arready;
            r = axi_rsp.rvalid;
            rd = axi_rsp.rdata;
            rs = axi_rsp.rresp;
            @(posedge aclk);
            n++;
            if (ar) axi_req.arvalid <= 1'b0;
        end while (!r && n < 50);
        axi_req.rready <= 1'b0;
        @(posedge aclk);
        if (!r) tmo();
    endtask : rdr
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic m, t8;
        logic [10:0] ew;
        int   nb, k;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rdr(ad(CTL3_IDX));
        check("ctl3", rd, 32'h0000_0000);
        rdr(ad(DATA_IDX));
        check("data", rd, 32'h0000_0000);
        @(negedge aclk);
        check("oe", txd_oe, 32'h0000_0001);
        check("irq", err_irq, 32'h0000_0000);
        @(posedge aclk);
        fin("reset");
        wr(ad(CTL3_IDX), 8'hFF);
        rdr(ad(CTL3_IDX, NONBLK_BASE));
        check("ctl3 alias", rd, 32'h0000_007F);
        rdr(ad(8'h49));
        check("unmapped resp", rs, RESP_SLVERR);
        check("unmapped data", rd, 32'h0000_0000);
        wr(ad(8'h49), 8'h00);
        check("unmapped wresp", rs, RESP_SLVERR);
        fin("decode");
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rdr(ad(CTL3_IDX));
        check("ctl3 reset", rd, 32'h0000_0000);
        @(negedge aclk);
        check("txd reset", txd_out, 32'h0000_0001);
        @(posedge aclk);
        fin("mid-run reset");
        loopback_select <= 1'b1;
        rx_source_select <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            wr(ad(CTL3_IDX, NONBLK_BASE), 8'(i << 5));
            @(negedge aclk);
            check("oe single", txd_oe, i);
            @(posedge aclk);
        end
        loopback_select <= 1'b0;
        fin("direction");
        undp_shifter_model_i.stall = 3;
        for (int i = 0; i < 4; i++) begin
            m = (i != 2);
            t8 = (i != 3);
            if (i == 0 || i == 3) wr(ad(CTL3_IDX), t8 ? 8'h50 : 8'h00);
            nine_bit_mode <= m;
            nb = undp_shifter_model_i.n_taken;
            wr(ad(DATA_IDX), tx_bytes[i]);
            for (k = 0; k < 50 && undp_shifter_model_i.n_taken == nb; k++) @(negedge aclk);
            if (k >= 50) tmo();
            ew = {1'b1, m ? t8 : 1'b1, tx_bytes[i], 1'b0};
            check("word", undp_shifter_model_i.last_word, ew);
            check("len", undp_shifter_model_i.last_len, m ? 11 : 10);
            for (k = 0; k < 11; k++) begin
                check("txd", txd_out, ew[k] ^ t8);
                @(negedge aclk);
            end
            @(posedge aclk);
        end
        rdr(ad(DATA_IDX));
        check("rx side", rd, 32'h0000_0000);
        fin("transmit");
        undp_shifter_model_i.send(9'h1C3, 3'b000);
        rdr(ad(CTL3_IDX));
        check("rx ninth", rd[7], 1'b1);
        rdr(ad(DATA_IDX));
        check("rx byte", rd, 32'h0000_00C3);
        undp_shifter_model_i.send(9'h0AA, 3'b000);
        rdr(ad(STAT_IDX));
        check("overrun", rd[4:0], 5'h18);
        rdr(ad(DATA_IDX));
        check("kept byte", rd, 32'h0000_00C3);
        rdr(ad(STAT_IDX));
        check("cleared", rd[4:0], 5'h00);
        fin("receive");
        for (int i = 0; i < 4; i++) begin
            for (int en = 1; en >= 0; en--) begin
                wr(ad(CTL3_IDX), en ? 8'(1 << i) : 8'(~(1 << i) & 15));
                if (i == ERR_OVERRUN) undp_shifter_model_i.send(9'h000, 3'b000);
                undp_shifter_model_i.send(9'h000, 3'(1 << i));
                @(negedge aclk);
                check("irq event", err_irq, en);
                @(posedge aclk);
                wr(ad(STAT_IDX), 8'h0F);
                rdr(ad(STAT_IDX));
                rdr(ad(DATA_IDX));
                @(negedge aclk);
                check("irq clear", err_irq, 32'h0000_0000);
                @(posedge aclk);
            end
        end
        fin("interrupt");
        end_of_test();
    end
endmodule : undp_data_port_test

// ==== dv/undp_shifter_model.sv ====
// Shifter-side partner: takes transmit words, shifts them, delivers characters
`timescale 1ns/1ps
module undp_shifter_model
    import undp_pkg::*;
(
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // Shifter side
    input  wire undp_tx_load_type tx_load,
    output logic                  tx_load_ready,
    output logic                  tx_shift_bit,
    output undp_rx_char_type      rx_char
);
    int          stall = 0;
    int          wait_n = 0;
    int          n_taken = 0;
    logic [3:0]  left = 4'h0;
    logic [10:0] shreg = 11'h7FF;
    logic [10:0] last_word = 11'h000;
    logic [3:0]  last_len = 4'h0;
    initial rx_char = '0;
    initial tx_shift_bit = 1'b1;
    assign tx_load_ready = aresetn && left == 4'h0 && wait_n >= stall;
    always @(posedge aclk) begin
        if (!aresetn) begin
            left <= 4'h0;
            wait_n <= 0;
            tx_shift_bit <= 1'b1;
        end else if (tx_load.valid && tx_load_ready) begin
            last_word <= tx_load.word;
            last_len <= tx_load.len;
            n_taken <= n_taken + 1;
            tx_shift_bit <= tx_load.word[0];
            shreg <= tx_load.word >> 1;
            left <= tx_load.len - 4'h1;
            wait_n <= 0;
        end else if (left != 4'h0) begin
            tx_shift_bit <= shreg[0];
            shreg <= shreg >> 1;
            left <= left - 4'h1;
        end else begin
            tx_shift_bit <= 1'b1;
            if (tx_load.valid) wait_n <= wait_n + 1;
        end
    end
    // One completed character, then stale fields inverted
    task automatic send(input logic [8:0] d, input logic [2:0] e);
        rx_char <= '{1'b1, d, e[2], e[1], e[0]};
        @(posedge aclk);
        rx_char <= '{1'b0, ~d, ~e[2], ~e[1], ~e[0]};
        @(posedge aclk);
    endtask : send
endmodule : undp_shifter_model

// ==== rtl/undp_data_port.sv ====
// Control register three, data register and error interrupt
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps

module undp_data_port
    import undp_pkg::*;
(
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             ce,
    // Register bus
    input  wire undp_axi_req_type axi_req,
    output undp_axi_rsp_type      axi_rsp,
    // Port configuration from other registers
    input  wire logic             nine_bit_mode,
    input  wire logic             loopback_select,
    input  wire logic             rx_source_select,
    // Receive shifter
    input  wire undp_rx_char_type rx_char,
    // Transmit shifter
    output undp_tx_load_type      tx_load,
    input  wire logic             tx_load_ready,
    input  wire logic             tx_shift_bit,
    // Transmit pin
    output logic                  txd_out,
    output logic                  txd_oe,
    // Status and interrupt
    output logic                  rx_buffer_full_flag,
    output logic                  err_irq
);
    import undp_pkg::*;

    typedef enum {
        SEL_NONE,
        SEL_CTL3,
        SEL_DATA,
        SEL_STAT
    } undp_sel_type;

    typedef struct packed {
        logic              have_aw;
        logic [9:0]        aw_idx;
        logic              have_w;
        logic [7:0]        w_data;
        logic              w_lane;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [1:0]        rresp;
        logic [7:0]        rdata;
        logic              rx_ninth_bit;
        logic              tx_ninth_bit;
        logic              single_wire_out_dir;
        logic              tx_polarity_flip;
        logic [ERR_W-1:0]  irq_en;
        logic [7:0]        rx_buf;
        logic              rx_full;
        logic [ERR_W-1:0]  armed;
        logic              armed_full;
        logic [10:0]       tx_word;
        logic [3:0]        tx_len;
        logic              tx_pending;
    } undp_state_type;

    undp_state_type   s;
    undp_state_type   next_s;
    logic [ERR_W-1:0] flags;
    logic [ERR_W-1:0] flag_set;
    logic [ERR_W-1:0] flag_clr;
    logic [10:0]      built_word;
    logic [3:0]       built_len;

    ////////////////////////////////////////////////////////////////////////////

    // Both base windows alias the same registers
    function automatic undp_sel_type decode(input logic [9:0] idx);
        undp_sel_type sel;
        sel = SEL_NONE;
        if (idx[9:8] == BLOCK_BASE[9:8] || idx[9:8] == NONBLK_BASE[9:8]) begin
            if (idx[7:0] == CTL3_IDX) begin
                sel = SEL_CTL3;
            end else if (idx[7:0] == DATA_IDX) begin
                sel = SEL_DATA;
            end else if (idx[7:0] == STAT_IDX) begin
                sel = SEL_STAT;
            end
        end
        return sel;
    endfunction : decode

    // Control three as read back; receive ninth bit is read-only
    function automatic logic [7:0] ctl3_view(input undp_state_type st);
        logic [7:0] v;
        v               = CTL3_RESET;
        v[CTL_RX_NINTH] = st.rx_ninth_bit;
        v[CTL_TX_NINTH] = st.tx_ninth_bit;
        v[CTL_DIR]      = st.single_wire_out_dir;
        v[CTL_FLIP]     = st.tx_polarity_flip;
        v[ERR_W-1:0]    = st.irq_en;
        return v;
    endfunction : ctl3_view

    ////////////////////////////////////////////////////////////////////////////

    // Shift word from the captured byte and the kept ninth bit
    undp_frame_builder u_builder (
        .data     (s.w_data),
        .ninth    (s.tx_ninth_bit),
        .nine_bit (nine_bit_mode),
        .word     (built_word),
        .len      (built_len)
    );

    // Error flags: a set beats a clear in the same cycle
    undp_sticky_flags #(
        .W (ERR_W)
    ) u_flags (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .set     (flag_set),
        .clr     (flag_clr),
        .q       (flags)
    );

    ////////////////////////////////////////////////////////////////////////////

    always_comb begin
        undp_sel_type wsel;
        undp_sel_type rsel;
        logic         do_write;
        logic         do_read;
        wsel     = decode(s.aw_idx);
        rsel     = decode(axi_req.araddr[11:2]);
        // Write executes once address and data are both held
        do_write = s.have_aw && s.have_w && !s.bvalid;
        do_read  = axi_req.arvalid && !s.rvalid;
        next_s   = s;
        flag_set = '0;
        flag_clr = '0;

        // Address and data taken in either order
        if (axi_req.awvalid && !s.have_aw && !s.bvalid) begin
            next_s.have_aw = 1'b1;
            next_s.aw_idx  = axi_req.awaddr[11:2];
        end
        if (axi_req.wvalid && !s.have_w && !s.bvalid) begin
            next_s.have_w = 1'b1;
            next_s.w_data = axi_req.wdata[7:0];
            next_s.w_lane = axi_req.wstrb[0];
        end
        if (s.bvalid && axi_req.bready) begin
            next_s.bvalid = 1'b0;
        end
        if (s.rvalid && axi_req.rready) begin
            next_s.rvalid = 1'b0;
        end

        // Shifter takes the waiting word
        if (s.tx_pending && tx_load_ready) begin
            next_s.tx_pending = 1'b0;
        end

        // Register writes
        if (do_write) begin
            next_s.have_aw = 1'b0;
            next_s.have_w  = 1'b0;
            next_s.bvalid  = 1'b1;
            next_s.bresp   = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            // Only byte lane zero carries a register
            if (s.w_lane) begin
                unique case (wsel)
                    SEL_CTL3: begin
                        next_s.tx_ninth_bit        = s.w_data[CTL_TX_NINTH];
                        next_s.single_wire_out_dir = s.w_data[CTL_DIR];
                        next_s.tx_polarity_flip    = s.w_data[CTL_FLIP];
                        next_s.irq_en              = s.w_data[ERR_W-1:0];
                    end
                    SEL_DATA: begin
                        // A word still waiting is replaced by the newer one
                        next_s.tx_word    = built_word;
                        next_s.tx_len     = built_len;
                        next_s.tx_pending = 1'b1;
                    end
                    SEL_STAT: begin
                        flag_clr = s.w_data[ERR_W-1:0];
                    end
                    SEL_NONE: begin
                    end
                endcase
            end
        end

        // Register reads and their side effects
        if (do_read) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            next_s.rdata  = 8'h00;
            // Unmapped reads return zero with an error response
            unique case (rsel)
                SEL_CTL3: begin
                    next_s.rdata = ctl3_view(s);
                end
                SEL_DATA: begin
                    next_s.rdata = s.rx_buf;
                    flag_clr     = flag_clr | (s.armed & flags);
                    if (s.armed_full) begin
                        next_s.rx_full = 1'b0;
                    end
                    // Any data read ends the sequence, armed or not
                    next_s.armed      = '0;
                    next_s.armed_full = 1'b0;
                end
                SEL_STAT: begin
                    next_s.rdata                = 8'h00;
                    next_s.rdata[ERR_W-1:0]     = flags;
                    next_s.rdata[STAT_RX_FULL]  = s.rx_full;
                    next_s.rdata[STAT_TX_EMPTY] = !s.tx_pending;
                    // Snapshot of what a following data read may clear
                    next_s.armed                = flags;
                    next_s.armed_full           = s.rx_full;
                end
                SEL_NONE: begin
                end
            endcase
        end

        // Character from the receive shifter
        if (rx_char.valid) begin
            // Full test sees the flag before a same-cycle clear
            if (s.rx_full) begin
                flag_set[ERR_OVERRUN] = 1'b1;
            end else begin
                next_s.rx_buf       = rx_char.data[7:0];
                // Ninth bit reads zero in eight-bit format
                next_s.rx_ninth_bit = nine_bit_mode & rx_char.data[8];
                next_s.rx_full      = 1'b1;
                flag_set[ERR_NOISE]   = rx_char.noise;
                flag_set[ERR_FRAMING] = rx_char.framing;
                flag_set[ERR_PARITY]  = rx_char.parity;
            end
        end
    end

    // Reset: single-wire pin listens, output not inverted, interrupts off
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    always_comb begin
        // Readies drop while a transfer is held or answered
        axi_rsp         = '0;
        axi_rsp.awready = !s.have_aw && !s.bvalid;
        axi_rsp.wready  = !s.have_w && !s.bvalid;
        axi_rsp.bvalid  = s.bvalid;
        axi_rsp.bresp   = s.bresp;
        axi_rsp.arready = !s.rvalid;
        axi_rsp.rvalid  = s.rvalid;
        axi_rsp.rdata   = {24'h00_0000, s.rdata};
        axi_rsp.rresp   = s.rresp;
    end

    // Waiting word offered to the shifter until taken
    assign tx_load.valid = s.tx_pending;
    assign tx_load.word  = s.tx_word;
    assign tx_load.len   = s.tx_len;

    // Pin drives only when not listening in single-wire mode
    assign txd_out = tx_shift_bit ^ s.tx_polarity_flip;
    assign txd_oe  = (loopback_select && rx_source_select) ? s.single_wire_out_dir : 1'b1;

    // Cleared by a status read followed by a data read
    assign rx_buffer_full_flag = s.rx_full;

    // Overrun, noise, framing, parity each gated by its enable
    assign err_irq = |(flags & s.irq_en);

endmodule : undp_data_port

// ==== rtl/undp_frame_builder.sv ====
// Builds the transmit shift word, LSB first
`timescale 1ns/1ps
module undp_frame_builder
    import undp_pkg::*;
(
    // Character in
    input  wire logic [7:0]  data,
    input  wire logic        ninth,
    input  wire logic        nine_bit,
    // Shift word out
    output logic      [10:0] word,
    output logic      [3:0]  len
);

    always_comb begin
        word      = 11'h7FF;
        word[0]   = 1'b0;
        word[8:1] = data;
        if (nine_bit) begin
            word[9] = ninth;
        end
        len = nine_bit ? FRAME_LEN_9 : FRAME_LEN_8;
    end

endmodule : undp_frame_builder

// ==== rtl/undp_pkg.sv ====
// Shared constants and carrier types for the ninth-bit data port
package undp_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] CTL3_IDX    = 8'h46;
    localparam logic [7:0] DATA_IDX    = 8'h47;
    localparam logic [7:0] STAT_IDX    = 8'h48;
    localparam logic [9:0] BLOCK_BASE  = 10'h200;
    localparam logic [9:0] NONBLK_BASE = 10'h300;

    // Control register three fields
    localparam int CTL_RX_NINTH = 7;
    localparam int CTL_TX_NINTH = 6;
    localparam int CTL_DIR      = 5;
    localparam int CTL_FLIP     = 4;

    // Error flags, same positions in status and enable fields
    localparam int ERR_OVERRUN = 3;
    localparam int ERR_NOISE   = 2;
    localparam int ERR_FRAMING = 1;
    localparam int ERR_PARITY  = 0;
    localparam int ERR_W       = 4;
    localparam int STAT_RX_FULL  = 4;
    localparam int STAT_TX_EMPTY = 5;

    localparam logic [7:0] CTL3_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Shift register lengths for eight- and nine-bit formats
    localparam logic [3:0] FRAME_LEN_8 = 4'd10;
    localparam logic [3:0] FRAME_LEN_9 = 4'd11;

    typedef struct packed {
        logic        awvalid;
        logic [11:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [11:0] araddr;
        logic        rready;
    } undp_axi_req_type;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } undp_axi_rsp_type;

    typedef struct packed {
        logic       valid;
        logic [8:0] data;
        logic       noise;
        logic       framing;
        logic       parity;
    } undp_rx_char_type;

    typedef struct packed {
        logic        valid;
        logic [10:0] word;
        logic [3:0]  len;
    } undp_tx_load_type;

endpackage : undp_pkg

// ==== rtl/undp_sticky_flags.sv ====
// Sticky event flags, set wins over clear
`timescale 1ns/1ps
module undp_sticky_flags #(
    parameter int W = 4
) (
    // Clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         ce,
    // Events and clears
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    // Flags
    output logic      [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] flags;
    } undp_sticky_type;

    undp_sticky_type s;
    undp_sticky_type next_s;

    always_comb begin
        next_s       = s;
        next_s.flags = (s.flags & ~clr) | set;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign q = s.flags;

endmodule : undp_sticky_flags
